// ---- rtl/frame_builder.sv ----
// host side builder of reset and flash update command frames, sent as a byte stream
// assumes the transport (udp stack) takes bytes on tx_valid and tx_ready, and that the
// caller supplies the whole-image checksum; payload bytes are buffered to checksum them first

module frame_builder
   import frame_build_pkg::*;
#(
   parameter int PAY_DEPTH = PAY_DEPTH_DEF,
   parameter int ADDR_W = $clog2(PAY_DEPTH)
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic cmd_start,
   input wire logic [7:0] cmd_code,
   input wire logic target_parallel,
   input wire logic new_transfer,
   input wire logic [31:0] flash_address,
   input wire logic [31:0] return_address,
   input wire logic [15:0] return_port,
   input wire logic [31:0] image_length,
   input wire logic [31:0] image_checksum,
   input wire logic pay_valid,
   input wire logic [7:0] pay_data,
   input wire logic pay_last,
   output logic pay_ready_ff,
   output logic [7:0] tx_data_ff,
   output logic tx_valid_ff,
   output logic tx_last_ff,
   input wire logic tx_ready,
   output logic busy_ff,
   output logic cmd_rejected_ff
);

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {b, 8'h00};
      for (int i = 0; i < 8; i++) begin
         r = r[15] ? ((r << 1) ^ CRC16_POLY) : (r << 1);
      end
      return r;
   endfunction : crc16_byte

   function automatic logic [31:0] crc32_byte(input logic [31:0] c, input logic [7:0] b);
      logic [31:0] r;
      r = c ^ {b, 24'h000000};
      for (int i = 0; i < 8; i++) begin
         r = r[31] ? ((r << 1) ^ CRC32_POLY) : (r << 1);
      end
      return r;
   endfunction : crc32_byte

   function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] k);
      return w[31 - 8 * k -: 8];
   endfunction : word_byte

   function automatic logic is_flash(input logic [7:0] c);
      return (c == CMD_BOOTLOADER) || (c == CMD_APPLICATION) ||
             (c == CMD_GENERIC) || (c == CMD_LENS_CAL);
   endfunction : is_flash

   // ************************************************************
   // state
   // ************************************************************
   state_type state_ff;
   logic [7:0] cmd_ff, qual_ff;
   logic [31:0] faddr_ff, raddr_ff, imglen_ff, imgcrc_ff, seq_ff, pcrc_ff;
   logic [15:0] rport_ff, crc16_ff, len_ff, idx_ff, pos_ff;
   logic [7:0] hdr_byte_c;
   logic [5:0] idx6;
   logic flash_c, start_ok, pay_acc, pay_end, slot_free, load_hdr, load_dat, dat_last;

   pay_mem_if #(.AW(ADDR_W), .W(8)) mem ();

   payload_store #(.W(8), .D(PAY_DEPTH), .AW(ADDR_W)) u_store (
      .core_clk(core_clk),
      .mem(mem.store)
   );

   assign flash_c = is_flash(cmd_ff);
   assign idx6 = idx_ff[5:0];
   // a new frame is refused until the previous one has fully left
   assign start_ok = cmd_start && !busy_ff && (is_flash(cmd_code) || cmd_code == CMD_RESET);
   assign pay_acc = pay_valid && pay_ready_ff;
   assign pay_end = pay_acc && (pay_last || len_ff == 16'(PAY_DEPTH - 1));
   assign slot_free = !tx_valid_ff || tx_ready;
   assign load_hdr = (state_ff == ST_HDR) && slot_free;
   assign load_dat = (state_ff == ST_DOUT) && slot_free;
   assign dat_last = (idx_ff == HDR_BYTES + len_ff - 16'h0001);
   assign mem.wr_en = pay_acc;
   assign mem.wr_addr = len_ff[ADDR_W-1:0];
   assign mem.wr_data = pay_data;
   assign mem.rd_addr = ADDR_W'(idx_ff - HDR_BYTES);

   // ************************************************************
   // header byte selection
   // ************************************************************
   always_comb begin
      hdr_byte_c = 8'h00;
      if (idx6 < OFS_REVISION) begin
         hdr_byte_c = idx6[0] ? FRAME_MARKER[7:0] : FRAME_MARKER[15:8];
      end else if (idx6 == OFS_REVISION) begin
         hdr_byte_c = PROTOCOL_REVISION;
      end else if (idx6 == OFS_COMMAND) begin
         hdr_byte_c = cmd_ff;
      end else if (idx6 == OFS_QUALIFIER) begin
         hdr_byte_c = qual_ff;
      end else if (idx6 >= OFS_STATUS && idx6 < OFS_LENGTH) begin
         // flags stay zero for both commands
         hdr_byte_c = idx6[0] ? FLAGS_VALUE[7:0] : FLAGS_VALUE[15:8];
      end else if (idx6 < OFS_FLASH_ADDR) begin
         hdr_byte_c = word_byte({16'h0000, len_ff}, 2'(idx6 - OFS_LENGTH));
      end else if (idx6 < OFS_IP_FAMILY) begin
         hdr_byte_c = word_byte(faddr_ff, 2'(idx6 - OFS_FLASH_ADDR));
      end else if (idx6 == OFS_IP_FAMILY) begin
         hdr_byte_c = RETURN_IP_FAMILY;
      end else if (idx6 < OFS_RET_PORT) begin
         hdr_byte_c = word_byte(raddr_ff, 2'(idx6 - OFS_RET_ADDR));
      end else if (idx6 < OFS_SEQUENCE) begin
         hdr_byte_c = (idx6 == OFS_RET_PORT) ? rport_ff[15:8] : rport_ff[7:0];
      end else if (idx6 < OFS_IMG_LEN) begin
         hdr_byte_c = word_byte(seq_ff, 2'(idx6 - OFS_SEQUENCE));
      end else if (idx6 < OFS_IMG_CRC) begin
         hdr_byte_c = word_byte(imglen_ff, 2'(idx6 - OFS_IMG_LEN));
      end else if (idx6 < OFS_RESERVED) begin
         hdr_byte_c = word_byte(imgcrc_ff, 2'(idx6 - OFS_IMG_CRC));
      end else if (idx6 >= OFS_PAY_CRC && idx6 < OFS_HDR_CRC) begin
         hdr_byte_c = flash_c ? word_byte(pcrc_ff, 2'(idx6 - OFS_PAY_CRC)) : 8'h00;
      end else if (idx6 == OFS_HDR_CRC) begin
         hdr_byte_c = crc16_ff[15:8];
      end else if (idx6 == OFS_LAST_HDR) begin
         hdr_byte_c = crc16_ff[7:0];
      end
   end

   // ************************************************************
   // sequencer
   // ************************************************************
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= ST_IDLE;
      end else begin
         case (state_ff)
            ST_IDLE: if (start_ok) state_ff <= is_flash(cmd_code) ? ST_LOAD : ST_HDR;
            ST_LOAD: if (pay_end) state_ff <= ST_HDR;
            ST_HDR: if (load_hdr && idx6 == OFS_LAST_HDR) begin
               state_ff <= (len_ff == 16'h0000) ? ST_IDLE : ST_RD;
            end
            ST_RD: state_ff <= ST_DOUT;
            ST_DOUT: if (load_dat) state_ff <= dat_last ? ST_IDLE : ST_RD;
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // command fields latched once per frame
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cmd_ff <= 8'h00;
         qual_ff <= 8'h00;
         faddr_ff <= 32'h0000_0000;
         raddr_ff <= 32'h0000_0000;
         rport_ff <= 16'h0000;
         imglen_ff <= 32'h0000_0000;
         imgcrc_ff <= 32'h0000_0000;
      end else if (start_ok) begin
         cmd_ff <= cmd_code;
         qual_ff <= 8'h00;
         faddr_ff <= 32'h0000_0000;
         if (cmd_code == CMD_GENERIC) begin
            qual_ff <= target_parallel ? QUAL_PARALLEL : QUAL_SERIAL;
            faddr_ff <= flash_address;
         end
         raddr_ff <= return_address;
         rport_ff <= return_port;
         // reset frames send zeros in the image fields
         imglen_ff <= is_flash(cmd_code) ? image_length : 32'h0000_0000;
         imgcrc_ff <= is_flash(cmd_code) ? image_checksum : 32'h0000_0000;
      end
   end

   // packet numbering across one image transfer
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         seq_ff <= 32'h0000_0000;
      end else if (start_ok && is_flash(cmd_code)) begin
         seq_ff <= new_transfer ? SEQ_FIRST : seq_ff + SEQ_FIRST;
      end
   end

   // payload intake with running crc-32
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pay_ready_ff <= 1'b0;
         len_ff <= 16'h0000;
         pcrc_ff <= CRC32_INIT;
      end else if (start_ok) begin
         pay_ready_ff <= is_flash(cmd_code);
         len_ff <= 16'h0000;
         pcrc_ff <= CRC32_INIT;
      end else if (pay_acc) begin
         pay_ready_ff <= !pay_end;
         len_ff <= len_ff + 16'h0001;
         pcrc_ff <= crc32_byte(pcrc_ff, pay_data);
      end
   end

   // header checksum over bytes 2..3d as they are emitted
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         crc16_ff <= CRC16_INIT;
      end else if (start_ok) begin
         crc16_ff <= CRC16_INIT;
      end else if (load_hdr && idx6 >= OFS_REVISION && idx6 < OFS_HDR_CRC) begin
         crc16_ff <= crc16_byte(crc16_ff, hdr_byte_c);
      end
   end

   // ************************************************************
   // byte stream out
   // ************************************************************
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         idx_ff <= 16'h0000;
         pos_ff <= 16'h0000;
         tx_data_ff <= 8'h00;
         tx_valid_ff <= 1'b0;
         tx_last_ff <= 1'b0;
      end else begin
         if (start_ok) begin
            idx_ff <= 16'h0000;
         end else if (load_hdr || load_dat) begin
            idx_ff <= idx_ff + 16'h0001;
         end
         // data bytes take two cycles each: one memory read, one load
         if (load_hdr || load_dat) begin
            pos_ff <= idx_ff;
            tx_data_ff <= load_hdr ? hdr_byte_c : mem.rd_data;
            tx_valid_ff <= 1'b1;
            tx_last_ff <= load_hdr ? (idx6 == OFS_LAST_HDR && len_ff == 16'h0000) : dat_last;
         end else if (tx_ready) begin
            tx_valid_ff <= 1'b0;
            tx_last_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_ff <= 1'b0;
         cmd_rejected_ff <= 1'b0;
      end else begin
         if (start_ok) begin
            busy_ff <= 1'b1;
         end else if (tx_valid_ff && tx_ready && tx_last_ff) begin
            busy_ff <= 1'b0;
         end
         cmd_rejected_ff <= cmd_start && !start_ok;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_marker_lead: assert property (
      tx_valid_ff && state_ff == ST_HDR && pos_ff == 16'h0000 |-> tx_data_ff == 8'ha1)
      else $error("marker high byte wrong");
   a_marker_low: assert property (
      tx_valid_ff && pos_ff == 16'h0001 && state_ff == ST_HDR |-> tx_data_ff == 8'hec)
      else $error("marker low byte wrong");
   a_revision_byte: assert property (
      tx_valid_ff && pos_ff == 16'h0002 && busy_ff |-> tx_data_ff == 8'h03)
      else $error("revision byte wrong");
   a_reset_zero_len: assert property (
      tx_valid_ff && cmd_ff == CMD_RESET && pos_ff >= 16'h0008 && pos_ff < 16'h000c
      |-> tx_data_ff == 8'h00)
      else $error("reset length not zero");
   a_flags_clear: assert property (
      tx_valid_ff && (pos_ff == 16'h0006 || pos_ff == 16'h0007) |-> tx_data_ff == 8'h00)
      else $error("flag byte not zero");
   a_ip_family: assert property (
      tx_valid_ff && pos_ff == 16'h0010 |-> tx_data_ff == 8'h04)
      else $error("ip family not 4");
   a_qual_generic: assert property (
      tx_valid_ff && pos_ff == 16'h0004 && cmd_ff != CMD_GENERIC |-> tx_data_ff == 8'h00)
      else $error("qualifier set for non-generic command");
   a_hdr_crc_tail: assert property (
      tx_valid_ff && pos_ff == 16'h003f && busy_ff |-> tx_data_ff == crc16_ff[7:0])
      else $error("header checksum low byte wrong");
   a_seq_first: assert property (
      start_ok && is_flash(cmd_code) && new_transfer |=> seq_ff == 32'h0000_0001)
      else $error("sequence did not restart at 1");
   a_seq_step: assert property (
      start_ok && is_flash(cmd_code) && !new_transfer |=> seq_ff == $past(seq_ff) + 32'h1)
      else $error("sequence did not step by one");
   a_last_at_len: assert property (
      tx_valid_ff && tx_last_ff |-> pos_ff == 16'h003f + len_ff)
      else $error("frame end disagrees with length");
   a_tx_hold: assert property (
      tx_valid_ff && !tx_ready |=> tx_valid_ff && $stable(tx_data_ff) && $stable(pos_ff))
      else $error("byte changed under back-pressure");

   c_reset_frame: cover property (
      tx_valid_ff && tx_ready && tx_last_ff && cmd_ff == CMD_RESET);
   c_generic_frame: cover property (
      tx_valid_ff && tx_ready && tx_last_ff && cmd_ff == CMD_GENERIC && len_ff > 16'h0002);
   c_stalled: cover property ((tx_valid_ff && !tx_ready) ##1 (tx_valid_ff && tx_ready));
   c_rejected: cover property (cmd_rejected_ff);

endmodule : frame_builder

// ---- rtl/frame_build_pkg.sv ----
// holds field offsets, fixed field values and checksum constants of the command frame
// assumes one clock domain; the frame builder and the bench import it
package frame_build_pkg;

   // ************************************************************
   // frame layout
   // ************************************************************
   localparam logic [5:0] OFS_MARKER = 6'h00;
   localparam logic [5:0] OFS_REVISION = 6'h02;
   localparam logic [5:0] OFS_COMMAND = 6'h03;
   localparam logic [5:0] OFS_QUALIFIER = 6'h04;
   localparam logic [5:0] OFS_STATUS = 6'h05;
   localparam logic [5:0] OFS_FLAGS = 6'h06;
   localparam logic [5:0] OFS_LENGTH = 6'h08;
   localparam logic [5:0] OFS_FLASH_ADDR = 6'h0c;
   localparam logic [5:0] OFS_IP_FAMILY = 6'h10;
   localparam logic [5:0] OFS_RET_ADDR = 6'h11;
   localparam logic [5:0] OFS_RET_PORT = 6'h15;
   localparam logic [5:0] OFS_SEQUENCE = 6'h17;
   localparam logic [5:0] OFS_IMG_LEN = 6'h1b;
   localparam logic [5:0] OFS_IMG_CRC = 6'h1f;
   localparam logic [5:0] OFS_RESERVED = 6'h23;
   localparam logic [5:0] OFS_PAY_CRC = 6'h3a;
   localparam logic [5:0] OFS_HDR_CRC = 6'h3e;
   localparam logic [5:0] OFS_LAST_HDR = 6'h3f;
   localparam logic [15:0] HDR_BYTES = 16'h0040;

   // ************************************************************
   // field values
   // ************************************************************
   localparam logic [15:0] FRAME_MARKER = 16'ha1ec;
   localparam logic [7:0] PROTOCOL_REVISION = 8'h03;
   localparam logic [7:0] RETURN_IP_FAMILY = 8'h04;
   localparam logic [7:0] CMD_RESET = 8'h07;
   localparam logic [7:0] CMD_BOOTLOADER = 8'h0b;
   localparam logic [7:0] CMD_APPLICATION = 8'h0c;
   localparam logic [7:0] CMD_GENERIC = 8'h0d;
   localparam logic [7:0] CMD_LENS_CAL = 8'h15;
   localparam logic [7:0] QUAL_SERIAL = 8'h00;
   localparam logic [7:0] QUAL_PARALLEL = 8'h01;
   localparam logic [15:0] FLAGS_VALUE = 16'h0000;
   localparam logic [31:0] SEQ_FIRST = 32'h0000_0001;

   // ************************************************************
   // checksums
   // ************************************************************
   localparam logic [15:0] CRC16_POLY = 16'h1021;
   localparam logic [15:0] CRC16_INIT = 16'h0000;
   localparam logic [31:0] CRC32_POLY = 32'h04c1_1db7;
   localparam logic [31:0] CRC32_INIT = 32'h0fff_ffff;

   localparam int PAY_DEPTH_DEF = 1024;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LOAD = 3'b001,
      ST_HDR = 3'b011,
      ST_RD = 3'b010,
      ST_DOUT = 3'b110
   } state_type;

endpackage : frame_build_pkg

// ---- rtl/pay_mem_if.sv ----
// carries the write and read ports of the payload store
// assumes both ends run on the same clock
interface pay_mem_if #(parameter int AW = 10, parameter int W = 8);
   logic wr_en;
   logic [AW-1:0] wr_addr;
   logic [W-1:0] wr_data;
   logic [AW-1:0] rd_addr;
   logic [W-1:0] rd_data;
   modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : pay_mem_if

// ---- rtl/payload_store.sv ----
// holds one packet's payload bytes until the header has gone out
// assumes a single clock; read data appear one edge after the address
module payload_store #(
   parameter int W = 8,
   parameter int D = 1024,
   parameter int AW = 10
) (
   input wire logic core_clk,
   pay_mem_if.store mem
);

   logic [W-1:0] ram [D];

   always_ff @(posedge core_clk) begin
      if (mem.wr_en) begin
         ram[mem.wr_addr] <= mem.wr_data;
      end
      mem.rd_data <= ram[mem.rd_addr];
   end

endmodule : payload_store

// ---- sim/cmd_sink_model.sv ----
// device-side model of the command channel: takes frame bytes and checks the header
// assumes the builder's byte stream with valid/ready on the one shared clock
module cmd_sink_model (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_last,
   input wire logic stall,
   output logic ready_ff,
   output logic hdr_ok_ff,
   output int frames_ff,
   output int last_len_ff,
   output int hold_err_ff
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] fb [0:127];
   logic [15:0] crc_ff;
   logic [9:0] held_ff;
   logic tgl_ff;
   int n_ff;

   function automatic logic [15:0] c16(input logic [15:0] c, input logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         c = (c[15] ^ d[i]) ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
      end
      return c;
   endfunction : c16

   // ************************************************************
   // sink
   // ************************************************************
   // flag field is never looked at: reset handling must not depend on it
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tgl_ff <= 1'b0;
         ready_ff <= 1'b0;
         n_ff <= 0;
         frames_ff <= 0;
         last_len_ff <= 0;
         hold_err_ff <= 0;
         hdr_ok_ff <= 1'b0;
         crc_ff <= 16'h0000;
         held_ff <= 10'h000;
      end else begin
         tgl_ff <= ~tgl_ff;
         // slow mode takes a byte only every second cycle
         ready_ff <= !stall || tgl_ff;
         held_ff <= {tx_valid && !ready_ff, tx_last, tx_data};
         if (held_ff[9] && {tx_valid, tx_last, tx_data} !== {1'b1, held_ff[8:0]}) begin
            hold_err_ff <= hold_err_ff + 1;
         end
         if (tx_valid && ready_ff) begin
            fb[n_ff] <= tx_data;
            n_ff <= tx_last ? 0 : n_ff + 1;
            if (n_ff >= 2 && n_ff <= 'h3d) begin
               crc_ff <= c16(crc_ff, tx_data);
            end
            if (n_ff == 'h3f) begin
               hdr_ok_ff <= {fb[0], fb[1], fb[2]} == 24'ha1ec03 && {fb['h3e], tx_data} == crc_ff;
            end
            if (tx_last) begin
               frames_ff <= frames_ff + 1;
               last_len_ff <= n_ff + 1;
               crc_ff <= 16'h0000;
            end
         end
      end
   end
endmodule : cmd_sink_model

// ---- sim/reset_flash_cmd_frame_decoder_tb.sv ----
// self-checking bench for the frame builder, driving it against the sink model
// assumes frame_build_pkg and a payload depth of 16 bytes
module reset_flash_cmd_frame_decoder_tb
   import frame_build_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int DEPTH = 16;
   typedef struct {
      logic [7:0] code;
      logic par;
      logic newt;
      logic [31:0] addr;
      logic [15:0] port;
      int npay;
      logic slow;
      logic [31:0] seq;
   } row_type;

   logic core_clk, arst_n, cmd_start, target_parallel, new_transfer, pay_valid, pay_last;
   logic [7:0] cmd_code, pay_data, tx_data_ff;
   logic [31:0] flash_address, return_address, image_length, image_checksum;
   logic [15:0] return_port;
   logic pay_ready_ff, tx_valid_ff, tx_last_ff, tx_ready, busy_ff, cmd_rejected_ff;
   logic stall, hdr_ok;
   int frames, last_len, hold_err, miscompares, samples_checked, w;
   logic [7:0] e [0:127];
   bit skip [0:127];
   row_type rows [0:5] = '{
      '{CMD_RESET, 1'b0, 1'b0, 32'h0, 16'h0, 0, 1'b0, 32'h0},
      '{CMD_BOOTLOADER, 1'b0, 1'b1, 32'hc0a8_0102, 16'h1f90, 3, 1'b1, 32'h1},
      '{CMD_APPLICATION, 1'b1, 1'b0, 32'h0a00_0001, 16'h0, DEPTH, 1'b0, 32'h2},
      '{CMD_GENERIC, 1'b0, 1'b1, 32'h0, 16'h2710, 5, 1'b1, 32'h1},
      '{CMD_GENERIC, 1'b1, 1'b0, 32'hffff_ffff, 16'hffff, 2, 1'b0, 32'h2},
      '{CMD_LENS_CAL, 1'b0, 1'b0, 32'h7f00_0001, 16'h1, 1, 1'b1, 32'h3}};

   frame_builder #(.PAY_DEPTH(DEPTH)) i_dut (.core_clk(core_clk), .arst_n(arst_n),
      .cmd_start(cmd_start), .cmd_code(cmd_code), .target_parallel(target_parallel),
      .new_transfer(new_transfer), .flash_address(flash_address),
      .return_address(return_address), .return_port(return_port),
      .image_length(image_length), .image_checksum(image_checksum), .pay_valid(pay_valid),
      .pay_data(pay_data), .pay_last(pay_last), .pay_ready_ff(pay_ready_ff),
      .tx_data_ff(tx_data_ff), .tx_valid_ff(tx_valid_ff), .tx_last_ff(tx_last_ff),
      .tx_ready(tx_ready), .busy_ff(busy_ff), .cmd_rejected_ff(cmd_rejected_ff));
   cmd_sink_model i_sink (.core_clk(core_clk), .arst_n(arst_n), .tx_data(tx_data_ff),
      .tx_valid(tx_valid_ff), .tx_last(tx_last_ff), .stall(stall), .ready_ff(tx_ready),
      .hdr_ok_ff(hdr_ok), .frames_ff(frames), .last_len_ff(last_len), .hold_err_ff(hold_err));

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic tick;
      @(posedge core_clk);
      #2;
   endtask : tick

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      chk({24'h0, got}, {24'h0, exp});
   endtask : cmp8

   task automatic cmp1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : cmp1

   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      chk(got, exp);
   endtask : cmp32

   function automatic logic [31:0] c32(input logic [31:0] c, input logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         c = (c[31] ^ d[i]) ? {c[30:0], 1'b0} ^ 32'h04c11db7 : {c[30:0], 1'b0};
      end
      return c;
   endfunction : c32

   task automatic tally_and_finish;
      $display("compares %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // builds the expected frame, runs one command and compares the captured frame
   task automatic run(input row_type r);
      logic [31:0] pc;
      int f0;
      pc = 32'h0fffffff;
      f0 = frames;
      foreach (e[i]) begin
         e[i] = 8'h00;
         skip[i] = 1'b0;
      end
      for (int k = 0; k < r.npay; k++) begin
         e[64 + k] = 8'h30 + 8'(k);
         pc = c32(pc, e[64 + k]);
      end
      {e[0], e[1], e[2], e[3], e[16]} = {16'ha1ec, 8'h03, r.code, 8'h04};
      {e[8], e[9], e[10], e[11]} = 32'(r.npay);
      {e[17], e[18], e[19], e[20], e[21], e[22]} = {r.addr, r.port};
      skip[4] = r.code != CMD_GENERIC;
      if (r.code == CMD_GENERIC) begin
         {e[4], e[12], e[13], e[14], e[15]} = {7'h00, r.par, flash_address};
      end
      if (r.code == CMD_RESET) begin
         {skip[23], skip[24], skip[25], skip[26]} = 4'hf;
      end else begin
         {e[23], e[24], e[25], e[26]} = r.seq;
         {e[27], e[28], e[29], e[30], e[31], e[32], e[33], e[34]} = {image_length, image_checksum};
         {e[58], e[59], e[60], e[61]} = pc;
      end
      {skip[62], skip[63]} = 2'b11;
      {cmd_code, target_parallel, new_transfer, return_address} = {r.code, r.par, r.newt, r.addr};
      return_port = r.port;
      stall = r.slow;
      cmd_start = 1'b1;
      tick;
      cmd_start = 1'b0;
      cmp1(busy_ff, 1'b1);
      cmp1(pay_ready_ff, r.code != CMD_RESET);
      for (int k = 0; k < r.npay; k++) begin
         {pay_valid, pay_last, pay_data} = {1'b1, k == r.npay - 1, e[64 + k]};
         for (w = 0; w < 50 && pay_ready_ff !== 1'b1; w++) tick;
         tick;
      end
      {pay_valid, pay_last} = 2'b00;
      cmp1(pay_ready_ff, 1'b0);
      for (w = 0; w < 1000 && busy_ff !== 1'b0; w++) tick;
      cmp1(busy_ff, 1'b0);
      for (int k = 0; k < 64 + r.npay; k++) begin
         if (!skip[k]) cmp8(i_sink.fb[k], e[k]);
      end
      cmp32(frames, f0 + 1);
      cmp32(last_len, 64 + r.npay);
      cmp1(hdr_ok, 1'b1);
   endtask : run

   // ************************************************************
   // stimulus
   // ************************************************************
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   initial begin
      #(20000 * 50);
      miscompares++;
      tally_and_finish;
   end

   initial begin
      {arst_n, cmd_start, target_parallel, new_transfer, pay_valid, pay_last, stall} = 7'h00;
      {cmd_code, pay_data, return_port, return_address} = 64'h0;
      {flash_address, image_length, image_checksum} = {32'h0012_3400, 32'h0001_2345, 32'hcafe_0001};
      repeat (5) @(posedge core_clk);
      #2;
      arst_n = 1'b1;
      foreach (rows[i]) run(rows[i]);
      // unknown code is refused and starts nothing
      {cmd_code, cmd_start} = {8'h04, 1'b1};
      tick;
      cmd_start = 1'b0;
      cmp1(cmd_rejected_ff, 1'b1);
      cmp1(busy_ff, 1'b0);
      tick;
      cmp1(cmd_rejected_ff, 1'b0);
      // a second start while busy is refused
      {cmd_code, cmd_start} = {CMD_RESET, 1'b1};
      tick;
      tick;
      cmp1(cmd_rejected_ff, 1'b1);
      cmd_start = 1'b0;
      // reset mid-frame must drop the stream and restart the sequence
      repeat (3) tick;
      arst_n = 1'b0;
      tick;
      cmp1(busy_ff, 1'b0);
      cmp1(tx_valid_ff, 1'b0);
      arst_n = 1'b1;
      run('{CMD_BOOTLOADER, 1'b0, 1'b0, 32'h0, 16'h0, 2, 1'b1, 32'h1});
      cmp32(hold_err, 32'h0);
      tally_and_finish;
   end
endmodule : reset_flash_cmd_frame_decoder_tb
